// [design/kwi_pkg.sv]
// Package with register map, field positions and reset values of the keypad interrupt block
// Notes on behaviour
// - Four lines, individual enables, shared mask, one request
// - Enabled line also switches on its pull-up
// - Latch when a line falls after all high
// - Edge mode ignores fall while another low
// - Level mode holds request while any line low
// - Level mode clears after ack and lines high
// - Vector fetch acknowledges the request
// - Ack bit clears request, reads zero
// - Fall after acknowledge latches a new request
// - Unmasked request uses vector at FFE0/FFE1
// - Edge mode ack clears request at once
// - Reset clears request and sensitivity select
// - Pending flag shows request regardless of mask
// - Mask bit blocks request to CPU
// - Sensitivity one is edge plus level
// - Enable forces line to input direction
// - Status register bits 7-4 read zero
// - Active in wait and stop; wakes CPU
// - During break, ack needs break clear enable
// - Enable bits read/write, reset to zero
package kwi_pkg;
    localparam int KWI_LINES = 4;
    // Byte addresses of the registers
    localparam logic [7:0] KWI_STATUS_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] KWI_ENABLE_ADDR = 8'h04;
    // Status and control field positions
    localparam int KWI_SENS_BIT = 0;
    localparam int KWI_MASK_BIT = 1;
    localparam int KWI_ACK_BIT = 2;
    localparam int KWI_PEND_BIT = 3;
    // Reset values
    localparam logic [3:0] KWI_ENABLE_RST = 4'h0;
    localparam logic KWI_MASK_RST = 1'b0;
    localparam logic KWI_SENS_RST = 1'b0;
    // Interrupt vector address pair
    localparam logic [15:0] KWI_VECTOR_HI_ADDR = 16'hffe0;
    localparam logic [15:0] KWI_VECTOR_LO_ADDR = 16'hffe1;
endpackage : kwi_pkg

// [design/kwi_sync.sv]
// Two flip-flop synchroniser for the keypad lines
module kwi_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '1;
            sync_out <= '1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : kwi_sync

// [design/kwi_keypad_irq.sv]
// Keypad wake-up interrupt unit with APB register access
module kwi_keypad_irq
    import kwi_pkg::*;
#(
    parameter int LINES = KWI_LINES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LINES-1:0] port_a_line,
    input wire logic [LINES-1:0] port_a_direction_bits,
    input wire logic vector_fetch,
    input wire logic break_state,
    input wire logic break_clear_enable,
    output logic [LINES-1:0] keypad_pullup_en,
    output logic [LINES-1:0] keypad_dir_out,
    output logic keypad_irq_req,
    output logic keypad_wakeup
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [LINES-1:0] keypad_line_enables_q;
    logic keypad_mask_q;
    logic keypad_sensitivity_select_q;
    logic latch_q;
    logic [LINES-1:0] line_sync;
    logic any_low_q;
    logic wr_fire;
    logic rd_fire;
    logic addr_ok;
    logic ack_wr;
    logic ack_any;
    logic any_low;
    logic fall_evt;
    logic req_now;

    // Address decode shared by read and write
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == KWI_STATUS_CONTROL_ADDR) || (a == KWI_ENABLE_ADDR);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Line synchronisation
    kwi_sync #(
        .WIDTH(LINES)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(port_a_line),
        .sync_out(line_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes
    assign addr_ok = mapped(paddr);
    assign wr_fire = psel && penable && pwrite && pready;
    assign rd_fire = psel && penable && !pwrite && pready;
    // Software acknowledge gated in break state
    assign ack_wr = wr_fire && addr_ok && (paddr == KWI_STATUS_CONTROL_ADDR) && pwdata[KWI_ACK_BIT]
        && (!break_state || break_clear_enable);
    assign ack_any = ack_wr || vector_fetch;
    // Enabled lines only
    assign any_low = |(keypad_line_enables_q & ~line_sync);
    // Fall when any goes low after all were high
    assign fall_evt = any_low && !any_low_q;

    // Previous all-high history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_low_q <= 1'b0;
        end else begin
            any_low_q <= any_low;
        end
    end

    // Request latch; a new fall wins over a clear
    // Level mode keeps the request alive through req_now while a line is low,
    // so an early ack still clears the latch and the request drops once lines rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= 1'b0;
        end else if (fall_evt) begin
            latch_q <= 1'b1;
        end else if (ack_any) begin
            latch_q <= 1'b0;
        end
    end

    // Level mode: request present while any enabled line low
    assign req_now = latch_q || (keypad_sensitivity_select_q && any_low);

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keypad_mask_q <= KWI_MASK_RST;
            keypad_sensitivity_select_q <= KWI_SENS_RST;
        end else if (wr_fire && paddr == KWI_STATUS_CONTROL_ADDR) begin
            keypad_mask_q <= pwdata[KWI_MASK_BIT];
            keypad_sensitivity_select_q <= pwdata[KWI_SENS_BIT];
        end
    end

    // Per-line enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keypad_line_enables_q <= KWI_ENABLE_RST;
        end else if (wr_fire && paddr == KWI_ENABLE_ADDR) begin
            keypad_line_enables_q <= pwdata[LINES-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite && paddr == KWI_STATUS_CONTROL_ADDR) begin
                prdata[KWI_PEND_BIT] <= req_now;
                prdata[KWI_MASK_BIT] <= keypad_mask_q;
                prdata[KWI_SENS_BIT] <= keypad_sensitivity_select_q;
            end else if (psel && !penable && !pwrite && paddr == KWI_ENABLE_ADDR) begin
                prdata[LINES-1:0] <= keypad_line_enables_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to pads and CPU
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keypad_pullup_en <= '0;
            keypad_dir_out <= '0;
            keypad_irq_req <= 1'b0;
            keypad_wakeup <= 1'b0;
        end else begin
            keypad_pullup_en <= keypad_line_enables_q;
            keypad_dir_out <= port_a_direction_bits & ~keypad_line_enables_q;
            keypad_irq_req <= req_now && !keypad_mask_q;
            keypad_wakeup <= req_now && !keypad_mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_fall;
        fall_evt && !ack_any;
    endsequence

    a_fall_sets_latch: assert property (@(posedge pclk) disable iff (!presetn)
        s_fall |=> latch_q) else $error("fall did not latch");
    a_edge_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (ack_any && !fall_evt && !keypad_sensitivity_select_q) |=> !latch_q) else $error("ack missed");
    a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (keypad_sensitivity_select_q && any_low && !keypad_mask_q) |=> keypad_irq_req)
        else $error("level lost");
    a_wake_matches: assert property (@(posedge pclk) disable iff (!presetn)
        keypad_wakeup == keypad_irq_req) else $error("wake differs");
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == KWI_ENABLE_ADDR) |=> keypad_line_enables_q == $past(pwdata[LINES-1:0]))
        else $error("enable write");
    a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        keypad_mask_q |=> !keypad_irq_req) else $error("mask leak");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        (req_now && !keypad_mask_q) |=> keypad_irq_req) else $error("irq late");
    a_break_protects: assert property (@(posedge pclk) disable iff (!presetn)
        (break_state && !break_clear_enable && !vector_fetch && latch_q) |=> latch_q)
        else $error("break clear");
    a_pullup_tracks: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> keypad_pullup_en == $past(keypad_line_enables_q)) else $error("pullup");
    a_direction_forced: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (keypad_dir_out & $past(keypad_line_enables_q)) == '0) else $error("dir");
    a_read_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:4] == 28'h0) else $error("upper bits");
    a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> !prdata[KWI_ACK_BIT] || paddr == KWI_ENABLE_ADDR) else $error("ack read");
endmodule : kwi_keypad_irq

// [testbench/kwi_keypad_model.sv]
// Keypad switch model driving the four port lines
module kwi_keypad_model (
    input wire logic pclk,
    input wire logic [3:0] press,
    input wire logic [3:0] pullup_en,
    output logic [3:0] line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;
    // Open pad without pull-up wanders each cycle
    always @(posedge pclk) flip <= ~flip;
    // Closed key grounds its line, open key follows the pull-up
    always_comb line = ~press & (pullup_en | {4{flip}});
endmodule : kwi_keypad_model

// [testbench/testbench.sv]
// Self-checking bench for the keypad interrupt unit
module testbench;
    import kwi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SC = KWI_STATUS_CONTROL_ADDR;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, vf = 1'b0, brk = 1'b0, bce = 1'b0, irq, wake;
    logic [3:0] press = 4'h0, line, pull, dir_out;
    int n_mismatch = 0, comparisons = 0;
    // 100 MHz clock
    initial forever #5 pclk = ~pclk;
    kwi_keypad_irq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_line(line), .port_a_direction_bits(4'hf), .vector_fetch(vf), .break_state(brk),
        .break_clear_enable(bce), .keypad_pullup_en(pull), .keypad_dir_out(dir_out),
        .keypad_irq_req(irq), .keypad_wakeup(wake));
    kwi_keypad_model i_keys (.pclk(pclk), .press(press), .pullup_en(pull), .line(line));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (k == 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rc
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial begin
        idle(3000);
        n_mismatch++;
        print_verdict();
    end
    // Main sequence
    initial begin
        idle(10);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(SC, 32'h0);
        rc(KWI_ENABLE_ADDR, 32'h0);
        wr(SC, 32'h2);
        wr(KWI_ENABLE_ADDR, 32'hf);
        idle(4);
        wr(SC, 32'h6);
        wr(SC, 32'hf0);
        check({pull, dir_out}, 8'hf0);
        rc(SC, 32'h0);
        rc(KWI_ENABLE_ADDR, 32'hf);
        press <= 4'h1;
        idle(6);
        check({irq, wake}, 2'b11);
        wr(SC, 32'h4);
        rc(SC, 32'h0);
        press <= 4'h3;
        idle(6);
        rc(SC, 32'h0);
        press <= 4'h0;
        idle(6);
        press <= 4'h4;
        idle(6);
        rc(SC, 32'h8);
        wr(SC, 32'h2);
        idle(1);
        check({irq, wake}, 2'b00);
        rc(SC, 32'ha);
        vf <= 1'b1;
        @(posedge pclk);
        vf <= 1'b0;
        idle(2);
        rc(SC, 32'h2);
        press <= 4'h0;
        idle(4);
        press <= 4'h8;
        idle(6);
        brk <= 1'b1;
        wr(SC, 32'h6);
        rc(SC, 32'ha);
        bce <= 1'b1;
        wr(SC, 32'h6);
        brk <= 1'b0;
        bce <= 1'b0;
        rc(SC, 32'h2);
        wr(SC, 32'h1);
        rc(SC, 32'h9);
        wr(SC, 32'h5);
        rc(SC, 32'h9);
        press <= 4'h0;
        idle(6);
        rc(SC, 32'h1);
        press <= 4'h2;
        idle(6);
        press <= 4'h0;
        idle(6);
        rc(SC, 32'h9);
        wr(SC, 32'h5);
        rc(SC, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        press <= 4'h1;
        idle(6);
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        idle(6);
        check(irq, 1'b0);
        check(dir_out, 4'hf);
        rc(SC, 32'h0);
        print_verdict();
    end
endmodule : testbench
